// ### shared/gpi_pkg.sv
package gpi_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int GPI_NUM_SRC = 11;
  localparam int GPI_NUM_GRP = 6;

  // ----------------------------------------------------------------
  // special function register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GPI_ADDR_ENABLE_EXT_B = 8'h9A;
  localparam logic [7:0] GPI_ADDR_LEVEL_LOW    = 8'hA9;
  localparam logic [7:0] GPI_ADDR_ENABLE_EXT_A = 8'hB8;
  localparam logic [7:0] GPI_ADDR_LEVEL_HIGH   = 8'hB9;
  localparam logic [7:0] GPI_RST_REG           = 8'h00;

  // writable bits per register; the rest read as zero
  localparam logic [7:0] GPI_MASK_ENABLE_EXT_A = 8'h7E;
  localparam logic [7:0] GPI_MASK_ENABLE_EXT_B = 8'h01;
  localparam logic [7:0] GPI_MASK_LEVEL_LOW    = 8'h7F;
  localparam logic [7:0] GPI_MASK_LEVEL_HIGH   = 8'h3F;

  // field positions
  localparam int GPI_BIT_EXT2_EN     = 1;
  localparam int GPI_BIT_EXT3_EN     = 2;
  localparam int GPI_BIT_EXT4_EN     = 3;
  localparam int GPI_BIT_EXT5_EN     = 4;
  localparam int GPI_BIT_EXT6_EN     = 5;
  localparam int GPI_BIT_WDT_START   = 6;
  localparam int GPI_BIT_SER1_EN     = 0;
  localparam int GPI_BIT_WDT_STATUS  = 6;

  // ----------------------------------------------------------------
  // sources in polling order: index 0 is polled first
  // 0 ext0, 1 ser1, 2 tmr0, 3 ext2, 4 ext1, 5 ext3,
  // 6 tmr1, 7 ser0, 8 ext4, 9 ext5, 10 ext6
  // ----------------------------------------------------------------
  localparam logic [2:0] GPI_GRP [GPI_NUM_SRC] = '{
    3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h3, 3'h4, 3'h5};

  localparam logic [15:0] GPI_VEC [GPI_NUM_SRC] = '{
    16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
    16'h001B, 16'h0023, 16'h005B, 16'h0063, 16'h006B};

  localparam logic [15:0] GPI_VEC_RESET = 16'h0000;
  localparam int          GPI_SRC_EXT0  = 0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } gpi_sfr_req_s;

  typedef struct packed {
    logic global;
    logic ext0;
    logic tmr0;
    logic ext1;
    logic tmr1;
    logic ser0;
  } gpi_base_en_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] vector;
    logic [1:0]  level;
    logic [3:0]  src;
  } gpi_irq_s;

endpackage

// ### rtl/gpi_ctrl.sv
// Functional notes
// - each of six groups gets its own software-chosen level of four
// - group level is high-register bit n over low-register bit n; 11 highest
// - fixed pairing of the eleven sources into six groups
// - equal-level requests resolved by fixed polling order, ext0 first
// - a source reaches the core only while its enable is set
// - per-source flag set by hardware, cleared when core vectors
// - fixed vector address per source, reset at zero
// - external 0 request wakes the stopped core
// - enable register a holds ext2..ext6 enables in bits 1..5; bit 6 inert
// - bit 0 of enable register b enables serial 1
// - only bits 0..5 of both level registers form group levels
// - every external source has a readable flag and an enable
`timescale 1ns/1ps
`default_nettype none

module gpi_ctrl
  import gpi_pkg::*;
(
  input  wire logic                   clock,        // core clock
  input  wire logic                   srst,         // sync reset, high
  input  wire gpi_sfr_req_s           sfr,          // sfr access from core
  output var  logic [7:0]             sfr_rdata_q,  // read data, next cycle
  input  wire logic [GPI_NUM_SRC-1:0] src_event,    // request pulses
  input  wire gpi_base_en_s           base_en,      // core-side enables
  input  wire logic                   cpu_stopped,  // core in power down
  input  wire logic                   irq_ack,      // core vectors now
  input  wire logic                   irq_reti,     // handler returns
  output var  gpi_irq_s               irq_q,        // request to core
  output var  logic [GPI_NUM_SRC-1:0] flags_q,      // request flags
  output var  logic                   wake_q        // wake from stop
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] enable_ext_a_q;
  logic [7:0] enable_ext_b_q;
  logic [7:0] level_low_q;
  logic [7:0] level_high_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      enable_ext_a_q <= GPI_RST_REG;
      enable_ext_b_q <= GPI_RST_REG;
      level_low_q    <= GPI_RST_REG;
      level_high_q   <= GPI_RST_REG;
    end else if (sfr.wr) begin
      if (sfr.addr == GPI_ADDR_ENABLE_EXT_A) begin
        enable_ext_a_q <= sfr.wdata & GPI_MASK_ENABLE_EXT_A;
      end else if (sfr.addr == GPI_ADDR_ENABLE_EXT_B) begin
        enable_ext_b_q <= sfr.wdata & GPI_MASK_ENABLE_EXT_B;
      end else if (sfr.addr == GPI_ADDR_LEVEL_LOW) begin
        level_low_q <= sfr.wdata & GPI_MASK_LEVEL_LOW;
      end else if (sfr.addr == GPI_ADDR_LEVEL_HIGH) begin
        level_high_q <= sfr.wdata & GPI_MASK_LEVEL_HIGH;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sfr_rdata_q <= GPI_RST_REG;
    end else if (sfr.rd) begin
      if (sfr.addr == GPI_ADDR_ENABLE_EXT_A) begin
        sfr_rdata_q <= enable_ext_a_q;
      end else if (sfr.addr == GPI_ADDR_ENABLE_EXT_B) begin
        sfr_rdata_q <= enable_ext_b_q;
      end else if (sfr.addr == GPI_ADDR_LEVEL_LOW) begin
        sfr_rdata_q <= level_low_q;
      end else if (sfr.addr == GPI_ADDR_LEVEL_HIGH) begin
        sfr_rdata_q <= level_high_q;
      end else begin
        sfr_rdata_q <= GPI_RST_REG;
      end
    end
  end

  // ----------------------------------------------------------------
  // enables and levels per source
  // ----------------------------------------------------------------
  logic [GPI_NUM_SRC-1:0] en_vec;
  logic [GPI_NUM_SRC-1:0] pending;
  logic [1:0]             src_lvl [GPI_NUM_SRC];

  // watchdog bits are stored but never reach this map
  assign en_vec = {enable_ext_a_q[GPI_BIT_EXT6_EN],
                   enable_ext_a_q[GPI_BIT_EXT5_EN],
                   enable_ext_a_q[GPI_BIT_EXT4_EN],
                   base_en.ser0,
                   base_en.tmr1,
                   enable_ext_a_q[GPI_BIT_EXT3_EN],
                   base_en.ext1,
                   enable_ext_a_q[GPI_BIT_EXT2_EN],
                   base_en.tmr0,
                   enable_ext_b_q[GPI_BIT_SER1_EN],
                   base_en.ext0};

  assign pending = flags_q & en_vec & {GPI_NUM_SRC{base_en.global}};

  for (genvar g = 0; g < GPI_NUM_SRC; g++) begin : g_lvl
    // only the low six bits are ever indexed
    assign src_lvl[g] = {level_high_q[GPI_GRP[g]], level_low_q[GPI_GRP[g]]};
  end

  // ----------------------------------------------------------------
  // in-service levels, one bit per level
  // ----------------------------------------------------------------
  logic [3:0] in_service_q;
  logic       svc_any;
  logic [1:0] cur_lvl;
  logic       take;
  logic [3:0] svc_after_reti;

  assign take    = irq_ack && irq_q.valid;
  assign svc_any = |in_service_q;

  always_comb begin
    cur_lvl = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (in_service_q[l]) begin
        cur_lvl = 2'(l);
      end
    end
  end

  always_comb begin
    svc_after_reti = in_service_q;
    if (irq_reti && svc_any) begin
      svc_after_reti[cur_lvl] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      in_service_q <= 4'h0;
    end else if (take) begin
      in_service_q <= svc_after_reti | (4'h1 << irq_q.level);
    end else begin
      in_service_q <= svc_after_reti;
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic       found;
  logic [1:0] best_lvl;
  logic [3:0] best_idx;
  logic       grant_ok;

  // walking down from the last source with >= leaves the earliest
  // polled source as winner among equals
  always_comb begin
    found    = 1'b0;
    best_lvl = 2'h0;
    best_idx = 4'h0;
    for (int i = GPI_NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i] && (!found || src_lvl[i] >= best_lvl)) begin
        found    = 1'b1;
        best_lvl = src_lvl[i];
        best_idx = 4'(i);
      end
    end
  end

  assign grant_ok = found && (!svc_any || best_lvl > cur_lvl);

  // one idle cycle after each take lets flags and levels settle
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_q.valid  <= 1'b0;
      irq_q.vector <= GPI_VEC_RESET;
      irq_q.level  <= 2'h0;
      irq_q.src    <= 4'h0;
    end else if (take) begin
      irq_q.valid <= 1'b0;
    end else begin
      irq_q.valid  <= grant_ok;
      irq_q.vector <= grant_ok ? GPI_VEC[best_idx] : GPI_VEC_RESET;
      irq_q.level  <= best_lvl;
      irq_q.src    <= best_idx;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic [GPI_NUM_SRC-1:0] flag_clr;

  assign flag_clr = take ? GPI_NUM_SRC'(1) << irq_q.src : '0;

  // a new event in the take cycle keeps its flag
  always_ff @(posedge clock) begin
    if (srst) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | src_event;
    end
  end

  // ----------------------------------------------------------------
  // wake from power down
  // ----------------------------------------------------------------
  // the global enable is ignored here; only the external 0 enable gates the wake
  always_ff @(posedge clock) begin
    if (srst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= cpu_stopped && flags_q[GPI_SRC_EXT0] && en_vec[GPI_SRC_EXT0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // level registers one cycle back, matching the state a shown request came from
  logic [7:0] level_low_prev_q;
  logic [7:0] level_high_prev_q;

  always_ff @(posedge clock) begin
    level_low_prev_q  <= level_low_q;
    level_high_prev_q <= level_high_q;
  end

  sequence seq_take;
    irq_ack && irq_q.valid;
  endsequence

  sequence seq_ext0_stopped;
    cpu_stopped && flags_q[GPI_SRC_EXT0] && en_vec[GPI_SRC_EXT0];
  endsequence

  AST_FLAG_SET: assert property (
    (src_event != '0) |=> ((flags_q & $past(src_event)) == $past(src_event)))
    else $error("event did not set its flag");

  AST_ACK_CLEAR: assert property (
    seq_take ##0 !src_event[irq_q.src] |=> !flags_q[$past(irq_q.src)])
    else $error("flag not cleared on vectoring");

  AST_ACK_GAP: assert property (
    seq_take |=> !irq_q.valid ##1 (in_service_q[$past(irq_q.level, 2)] || $past(irq_reti)))
    else $error("no gap or level not in service after take");

  AST_ENABLED: assert property (
    irq_q.valid && !$past(take) |->
      ($past(pending) & (GPI_NUM_SRC'(1) << irq_q.src)) != '0)
    else $error("request shown for blocked source");

  AST_VECTOR: assert property (
    irq_q.valid |-> irq_q.vector == GPI_VEC[irq_q.src])
    else $error("wrong vector address");

  AST_LEVEL: assert property (
    irq_q.valid && !$past(take) |->
      irq_q.level == {level_high_prev_q[GPI_GRP[irq_q.src]],
                      level_low_prev_q[GPI_GRP[irq_q.src]]})
    else $error("request level does not match group level");

  AST_PREEMPT: assert property (
    irq_q.valid && !$past(take) && $past(svc_any) |-> irq_q.level > $past(cur_lvl))
    else $error("preempted without higher level");

  AST_WAKE: assert property (
    seq_ext0_stopped |=> wake_q)
    else $error("no wake for external 0 while stopped");

  AST_REG_WRITE: assert property (
    sfr.wr && sfr.addr == GPI_ADDR_ENABLE_EXT_A |=>
      enable_ext_a_q == ($past(sfr.wdata) & GPI_MASK_ENABLE_EXT_A))
    else $error("enable register a write lost");

  AST_EXT_B_WRITE: assert property (
    sfr.wr && sfr.addr == GPI_ADDR_ENABLE_EXT_B |=>
      enable_ext_b_q == ($past(sfr.wdata) & GPI_MASK_ENABLE_EXT_B))
    else $error("enable register b write lost");

  AST_GLOBAL_OFF: assert property (
    !base_en.global |=> !irq_q.valid)
    else $error("request shown while global enable is off");

  AST_FLAG_DROP: assert property (
    (($past(flags_q) & ~flags_q) != '0) |-> $past(take))
    else $error("flag cleared without vectoring");

  AST_WAKE_CAUSE: assert property (
    wake_q |-> $past(cpu_stopped) && $past(flags_q[GPI_SRC_EXT0]))
    else $error("wake without stopped core and external 0 flag");

  AST_SVC_RET: assert property (
    irq_reti && svc_any && !take |=> !in_service_q[$past(cur_lvl)])
    else $error("handler return did not release its level");

  // the shown winner beats every other source that was pending
  for (genvar p = 0; p < GPI_NUM_SRC; p++) begin : g_poll_chk
    AST_POLL_WIN: assert property (@(posedge clock) disable iff (srst)
      irq_q.valid && !$past(take) && $past(pending[p]) |->
        (irq_q.level > $past(src_lvl[p])) ||
        (irq_q.level == $past(src_lvl[p]) && irq_q.src <= 4'(p)))
      else $error("shown request loses to another pending source");
  end

endmodule

`default_nettype wire

// ### verif/gpi_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// core side: takes a shown vector after a chosen wait
// ----------------------------------------------------------------
module gpi_core_model
  import gpi_pkg::*;
(
  input  wire logic       clock,    // core clock
  input  wire logic       srst,     // sync reset, high
  input  wire gpi_irq_s   irq,      // request from controller
  input  wire logic       ack_on,   // core accepts interrupts
  input  wire logic       auto_ret, // return right after entry
  input  wire logic       ret_req,  // commanded handler return
  input  wire logic [3:0] wait_n,   // cycles before taking
  output var  logic       ack_q,    // vector taken
  output var  logic       ret_q     // handler return
);
  logic [3:0] cnt_q;

  // ack is a one-cycle pulse; the request drops before a second one
  always_ff @(posedge clock) begin
    ack_q <= 1'b0;
    ret_q <= ret_req | (auto_ret & ack_q);
    if (srst) begin
      cnt_q <= 4'h0;
      ret_q <= 1'b0;
    end else if (ack_on && irq.valid && !ack_q) begin
      if (cnt_q == wait_n) begin
        ack_q <= 1'b1;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ### verif/grouped_priority_interrupt_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module grouped_priority_interrupt_ctrl_test
  import gpi_pkg::*;
;
  logic         clock, srst, stopped, ack, reti, wake, ack_on, auto, ret;
  gpi_sfr_req_s sfr;
  gpi_base_en_s ben;
  gpi_irq_s     irq;
  logic [7:0]   rdata;
  logic [10:0]  ev, flags;
  logic [3:0]   wt;
  int           err_count, checks_done;

  gpi_ctrl uut (.clock(clock), .srst(srst), .sfr(sfr), .sfr_rdata_q(rdata),
    .src_event(ev), .base_en(ben), .cpu_stopped(stopped), .irq_ack(ack),
    .irq_reti(reti), .irq_q(irq), .flags_q(flags), .wake_q(wake));
  gpi_core_model core (.clock(clock), .srst(srst), .irq(irq), .ack_on(ack_on),
    .auto_ret(auto), .ret_req(ret), .wait_n(wt), .ack_q(ack), .ret_q(reti));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock); #1;
    sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clock); #1;
    sfr = '0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clock); #1;
    sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clock); #1;
    sfr = '0;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic fire(logic [10:0] m);
    @(posedge clock); #1;
    ev = m;
    @(posedge clock); #1;
    ev = '0;
  endtask
  // bounded wait for the core to take a vector
  task automatic take(logic [15:0] v);
    int i;
    logic [3:0] s;
    i = 0;
    s = 4'h0;
    for (int k = 0; k < GPI_NUM_SRC; k++) begin
      if (GPI_VEC[k] == v) begin
        s = 4'(k);
      end
    end
    while (ack !== 1'b1 && i < 60) begin
      @(posedge clock); #1;
      i++;
    end
    chk("ack", 16'h0001, {15'h0000, ack});
    chk("vector", v, irq.vector);
    chk("src", {12'h000, s}, {12'h000, irq.src});
    @(posedge clock); #1;
  endtask
  task automatic idle(int n);
    repeat (n) begin
      @(posedge clock); #1;
      chk("valid", 16'h0000, {15'h0000, irq.valid});
    end
  endtask
  task automatic ret_pulse();
    @(posedge clock); #1;
    ret = 1'b1;
    @(posedge clock); #1;
    ret = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] ad [5] = '{GPI_ADDR_ENABLE_EXT_A, GPI_ADDR_ENABLE_EXT_B,
      GPI_ADDR_LEVEL_LOW, GPI_ADDR_LEVEL_HIGH, 8'h9B};
    logic [7:0] mk [5] = '{8'h7E, 8'h01, 8'h7F, 8'h3F, 8'h00};
    for (int i = 0; i < 5; i++) rd(ad[i], 8'h00);
    for (int i = 0; i < 5; i++) wr(ad[i], 8'hFF);
    for (int i = 0; i < 5; i++) rd(ad[i], mk[i]);
    wr(GPI_ADDR_LEVEL_LOW, 8'h00);
    wr(GPI_ADDR_LEVEL_HIGH, 8'h00);
    wr(GPI_ADDR_ENABLE_EXT_A, 8'h3E);
    $display("test regs done");
  endtask
  task automatic t_poll();
    logic [15:0] v [11] = '{16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013,
      16'h0053, 16'h001B, 16'h0023, 16'h005B, 16'h0063, 16'h006B};
    fire(11'h7FF);
    for (int i = 0; i < 11; i++) take(v[i]);
    chk("flags", 16'h0000, {5'h00, flags});
    $display("test poll done");
  endtask
  task automatic t_level();
    wt = 4'h3;
    wr(GPI_ADDR_LEVEL_LOW, 8'h20);
    wr(GPI_ADDR_LEVEL_HIGH, 8'h20);
    fire(11'h401);
    @(posedge clock); #1;
    chk("level", 16'h0003, {14'h0000, irq.level});
    take(16'h006B);
    take(16'h0003);
    wt = 4'h0;
    $display("test level done");
  endtask
  task automatic t_preempt();
    auto = 1'b0;
    wr(GPI_ADDR_LEVEL_LOW, 8'h05);
    wr(GPI_ADDR_LEVEL_HIGH, 8'h01);
    fire(11'h010);
    take(16'h0013);
    fire(11'h020);
    idle(6);
    fire(11'h001);
    take(16'h0003);
    ret_pulse();
    idle(4);
    ret_pulse();
    take(16'h0053);
    ret_pulse();
    auto = 1'b1;
    wr(GPI_ADDR_LEVEL_LOW, 8'h00);
    wr(GPI_ADDR_LEVEL_HIGH, 8'h00);
    $display("test preempt done");
  endtask
  task automatic t_enable();
    wr(GPI_ADDR_ENABLE_EXT_A, 8'h3A);
    fire(11'h020);
    idle(6);
    chk("flags", 16'h0020, {5'h00, flags});
    wr(GPI_ADDR_ENABLE_EXT_A, 8'h3E);
    take(16'h0053);
    ben.global = 1'b0;
    fire(11'h001);
    idle(4);
    ben.global = 1'b1;
    take(16'h0003);
    $display("test enable done");
  endtask
  task automatic t_wake();
    ack_on = 1'b0;
    stopped = 1'b1;
    fire(11'h001);
    @(posedge clock); #1;
    chk("wake", 16'h0001, {15'h0000, wake});
    ack_on = 1'b1;
    take(16'h0003);
    @(posedge clock); #1;
    chk("wake", 16'h0000, {15'h0000, wake});
    stopped = 1'b0;
    $display("test wake done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // run takes under two hundred cycles; this bound is generous
  initial begin
    #20000;
    err_count++;
    final_report();
  end
  initial begin
    srst = 1'b1;
    sfr = '0;
    ev = '0;
    ben = '1;
    stopped = 1'b0;
    ack_on = 1'b1;
    auto = 1'b1;
    ret = 1'b0;
    wt = 4'h0;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    #1;
    srst = 1'b0;
    t_regs();
    wr(GPI_ADDR_ENABLE_EXT_B, 8'h01);
    t_poll();
    t_level();
    t_preempt();
    t_enable();
    t_wake();
    final_report();
  end
endmodule

`default_nettype wire
